// [hw/seg_lcd_pkg.sv]
// Register map, field positions and shared types of the segment display driver
package seg_lcd_pkg;
   localparam int         NUM_PINS    = 64;
   localparam int         ADDR_W      = 8;
   // Register byte offsets
   localparam logic [7:0] MAIN_OFS    = 8'h00;
   localparam logic [7:0] POWER_OFS   = 8'h04;
   localparam logic [7:0] SUPPLY_OFS  = 8'h08;
   localparam logic [7:0] BLINK_OFS   = 8'h0C;
   localparam logic [7:0] STATUS_OFS  = 8'h10;
   localparam logic [7:0] IRQ_CLR_OFS = 8'h14;
   localparam logic [7:0] IRQ_EN_OFS  = 8'h18;
   localparam logic [7:0] PEN_LO_OFS  = 8'h20;
   localparam logic [7:0] PEN_HI_OFS  = 8'h24;
   localparam logic [7:0] BP_LO_OFS   = 8'h28;
   localparam logic [7:0] BP_HI_OFS   = 8'h2C;
   localparam logic [7:0] WF_BASE     = 8'h40;
   localparam logic [7:0] WF_LAST     = 8'h7C;
   // Main control fields
   localparam int         ENABLE_BIT  = 7;
   localparam int         SOURCE_BIT  = 6;
   localparam int         LCLK_LSB    = 3;
   localparam int         DUTY_LSB    = 0;
   // Power mode control fields
   localparam int         IRQEN_BIT   = 2;
   localparam int         WAIT_BIT    = 1;
   localparam int         STOP_BIT    = 0;
   // Supply control fields
   localparam int         CP_BIT      = 7;
   localparam int         MULT_BIT    = 6;
   localparam int         LADJ_LSB    = 4;
   localparam int         BYPASS_BIT  = 2;
   localparam int         VSUP_LSB    = 0;
   localparam logic [1:0] VSUP_EXT    = 2'h2;
   // Blink control fields
   localparam int         BLINK_BIT   = 7;
   localparam int         ALT_BIT     = 6;
   localparam int         BLANK_BIT   = 5;
   localparam int         BLINK_STYLE_BIT   = 3;
   localparam int         BRATE_LSB   = 0;
   // Writable bit masks and reset values
   localparam logic [7:0] POWER_MASK  = 8'h07;
   localparam logic [7:0] SUPPLY_MASK = 8'hF7;
   localparam logic [7:0] BLINK_MASK  = 8'hEF;
   localparam logic [7:0] MAIN_RST    = 8'h03;
   // Source ticks per phase for each divider step; phase offset of the alternate display
   localparam logic [7:0] PHASE_UNIT  = 8'h17;
   localparam logic [2:0] ALT_SHIFT   = 3'h4;

   // Analog front-end controls driven to the bias and pump cells
   typedef struct packed {
      logic       charge_pump_on;
      logic       pump_tripler;
      logic       bias_buffer_on;
      logic       ext_supply_select;
      logic [1:0] pump_clock_adjust;
   } power_ctl_s;

   typedef enum logic [1:0] {
      BUS_ADDR = 2'b01,
      BUS_WR   = 2'b10
   } bus_e;
endpackage

// [hw/frame_seq.sv]
// Phase and frame timer stepping on the selected display clock ticks
`timescale 1ns/1ps
module frame_seq
   import seg_lcd_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       tick,
   input  wire logic       run,
   input  wire logic [2:0] rate,
   input  wire logic [2:0] duty,
   output logic [2:0]      phase,
   output logic            frame_done
);
   typedef struct packed {
      logic [7:0] cnt;
      logic [2:0] phase;
      logic       done;
   } seq_s;

   seq_s       s_r;
   seq_s       s_nxt;
   logic [7:0] limit;

   // Ticks per phase grow linearly with the divider setting
   assign limit = 8'(PHASE_UNIT * ({5'h00, rate} + 8'h01) - 8'h01);

   // Step phases 0..duty, one frame per full sweep
   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      if (!run) begin
         s_nxt.cnt   = 8'h00;
         s_nxt.phase = 3'h0;
      end else if (tick) begin
         if (s_r.cnt >= limit) begin
            s_nxt.cnt = 8'h00;
            if (s_r.phase >= duty) begin
               s_nxt.phase = 3'h0;
               s_nxt.done  = 1'b1;
            end else begin
               s_nxt.phase = s_r.phase + 3'h1;
            end
         end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign phase      = s_r.phase;
   assign frame_done = s_r.done;

   frame_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.done |-> s_r.phase == 3'h0 && $past(s_r.phase) >= $past(duty))
      else $error("frame ended before last phase");
endmodule

// [hw/seg_lcd_ctrl.sv]
// Segment display driver: AHB-Lite registers, pin drive and frame interrupt
// Operation
// - Pump multiplier bit 0 selects doubler, 1 selects tripler.
// - Bypass bit 0 uses bias buffer, 1 runs unbuffered.
// - Supply field 10 selects the external display supply pin.
// - Wait-mode bit 0 keeps the display driven during wait.
// - Stop-mode bit 0 keeps the display driven during stop.
// - Stop-mode bit 1 turns the drive off during stop.
// - Clock source bit 0 takes the external oscillator ticks.
// - Duty field 111 gives eight backplane phases.
// - Duty field 011 gives four backplane phases.
// - Divider 101 at 32.768 kHz, eighth duty, lands nearest 30 Hz.
// - Blink style 0 blanks the display, 1 shows the alternate one.
// - Frame interrupt enable 0 keeps the interrupt output low.
// - Any pin may be enabled for display use by its own bit.
// - Any enabled pin becomes a backplane through its select bit.
// - Backplane waveform bits are a phase mask; 00000001 means phase A.
// - Any backplane pin may be given any phase.
// - Module enable clear holds every driver output in high impedance.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module seg_lcd_ctrl
   import seg_lcd_pkg::*;
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic                hready,
   input  wire logic [31:0]         hwdata,
   output logic [31:0]              hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic                ext_osc_tick,
   input  wire logic                alt_clk_tick,
   input  wire logic                cpu_wait,
   input  wire logic                cpu_stop,
   output logic [NUM_PINS-1:0]      lcd_level,
   output logic [NUM_PINS-1:0]      lcd_oe,
   output power_ctl_s               power_out,
   output logic                     clock_is_external,
   output logic                     frame_irq
);
   typedef struct packed {
      bus_e                        bus;
      logic [ADDR_W-1:0]           waddr;
      logic [7:0]                  main_c;
      logic [7:0]                  power_c;
      logic [7:0]                  supply_c;
      logic [7:0]                  blink_c;
      logic [NUM_PINS-1:0]         pen;
      logic [NUM_PINS-1:0]         bpen;
      logic [NUM_PINS-1:0][7:0]    wf;
      logic                        frame_flag;
      logic [7:0]                  blink_cnt;
      logic [31:0]                 rdata;
      logic                        rdy;
      logic                        resp;
      logic [NUM_PINS-1:0]         level;
      logic [NUM_PINS-1:0]         oe;
      power_ctl_s                  pwr;
      logic                        clk_ext;
      logic                        irq;
   } st_s;

   localparam st_s ST_RST = '{bus: BUS_ADDR, main_c: MAIN_RST, rdy: 1'b1, default: '0};

   st_s        s_r;
   st_s        n;
   logic [2:0] seq_phase;
   logic       frame_done;
   logic       drive_on;
   logic       src_tick;
   logic       clr_flag;

   // Waveform window covers one byte per pin, four pins a word
   function automatic logic is_wf(input logic [ADDR_W-1:0] a);
      return (a >= WF_BASE) && (a <= WF_LAST);
   endfunction

   function automatic logic [5:0] wf_pin(input logic [ADDR_W-1:0] a);
      return 6'(a - WF_BASE);
   endfunction

   // Read view; reserved and unmapped bits read as zero
   function automatic logic [31:0] read_word(input st_s s, input logic [ADDR_W-1:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         MAIN_OFS:   w[7:0] = s.main_c;
         POWER_OFS:  w[7:0] = s.power_c;
         SUPPLY_OFS: w[7:0] = s.supply_c;
         BLINK_OFS:  w[7:0] = s.blink_c;
         STATUS_OFS: w[0] = s.frame_flag;
         IRQ_EN_OFS: w[0] = s.power_c[IRQEN_BIT];
         PEN_LO_OFS: w = s.pen[31:0];
         PEN_HI_OFS: w = s.pen[63:32];
         BP_LO_OFS:  w = s.bpen[31:0];
         BP_HI_OFS:  w = s.bpen[63:32];
         default: begin
            if (is_wf(a)) begin
               w = s.wf[wf_pin(a) +: 4];
            end
         end
      endcase
      return w;
   endfunction

   // Low-power gating of the whole drive
   assign drive_on = s_r.main_c[ENABLE_BIT]
                   & ~(cpu_wait & s_r.power_c[WAIT_BIT])
                   & ~(cpu_stop & s_r.power_c[STOP_BIT]);

   // Clock source choice feeds the frame timer
   assign src_tick = s_r.main_c[SOURCE_BIT] ? alt_clk_tick : ext_osc_tick;

   assign clr_flag = (s_r.bus == BUS_WR) && (s_r.waddr == IRQ_CLR_OFS) && hwdata[0];

   frame_seq u_seq (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .tick       (src_tick),
      .run        (drive_on),
      .rate       (s_r.main_c[LCLK_LSB +: 3]),
      .duty       (s_r.main_c[DUTY_LSB +: 3]),
      .phase      (seq_phase),
      .frame_done (frame_done)
   );

   // Next-state logic: bus slave, interrupt, blink and pin drive
   always_comb begin
      logic       blink_on;
      logic       show_blank;
      logic       show_alt;
      logic [2:0] ph_alt;
      n          = s_r;
      blink_on   = 1'b0;
      show_blank = 1'b0;
      show_alt   = 1'b0;
      ph_alt     = seq_phase + ALT_SHIFT;

      // Data phase of a write; only whole words are expected
      if (s_r.bus == BUS_WR) begin
         n.bus = BUS_ADDR;
         case (s_r.waddr)
            MAIN_OFS:   n.main_c = hwdata[7:0];
            POWER_OFS:  n.power_c = hwdata[7:0] & POWER_MASK;
            SUPPLY_OFS: n.supply_c = hwdata[7:0] & SUPPLY_MASK;
            BLINK_OFS:  n.blink_c = hwdata[7:0] & BLINK_MASK;
            IRQ_EN_OFS: n.power_c[IRQEN_BIT] = hwdata[0];
            PEN_LO_OFS: n.pen[31:0] = hwdata;
            PEN_HI_OFS: n.pen[63:32] = hwdata;
            BP_LO_OFS:  n.bpen[31:0] = hwdata;
            BP_HI_OFS:  n.bpen[63:32] = hwdata;
            default: begin
               if (is_wf(s_r.waddr)) begin
                  n.wf[wf_pin(s_r.waddr) +: 4] = hwdata;
               end
            end
         endcase
      end

      // Address phase; reads answer with zero wait states
      if (hsel && htrans[1] && hready) begin
         if (hwrite) begin
            n.bus   = BUS_WR;
            n.waddr = haddr[ADDR_W-1:0];
         end else begin
            n.rdata = read_word(s_r, haddr[ADDR_W-1:0]);
         end
      end

      // Sticky frame flag; a new frame beats a clear in the same cycle
      n.frame_flag = (s_r.frame_flag & ~clr_flag) | frame_done;
      n.irq        = n.frame_flag & n.power_c[IRQEN_BIT];
      if (frame_done) begin
         n.blink_cnt = s_r.blink_cnt + 8'h01;
      end

      // Blink window picks blank or alternate by style
      blink_on   = s_r.blink_c[BLINK_BIT] & s_r.blink_cnt[s_r.blink_c[BRATE_LSB +: 3]];
      show_blank = s_r.blink_c[BLANK_BIT] | (blink_on & ~s_r.blink_c[BLINK_STYLE_BIT]);
      show_alt   = s_r.blink_c[ALT_BIT] | (blink_on & s_r.blink_c[BLINK_STYLE_BIT]);

      // Per-pin drive; backplanes ignore blanking so the glass stays biased
      for (int i = 0; i < NUM_PINS; i++) begin
         n.oe[i] = drive_on & s_r.pen[i];
         if (!n.oe[i]) begin
            n.level[i] = 1'b0;
         end else if (s_r.bpen[i]) begin
            n.level[i] = s_r.wf[i][seq_phase];
         end else begin
            n.level[i] = ~show_blank & s_r.wf[i][show_alt ? ph_alt : seq_phase];
         end
      end

      // Analog controls follow the supply register
      n.pwr.charge_pump_on    = s_r.supply_c[CP_BIT];
      n.pwr.pump_tripler      = s_r.supply_c[MULT_BIT];
      n.pwr.bias_buffer_on    = ~s_r.supply_c[BYPASS_BIT];
      n.pwr.ext_supply_select = (s_r.supply_c[VSUP_LSB +: 2] == VSUP_EXT);
      n.pwr.pump_clock_adjust = s_r.supply_c[LADJ_LSB +: 2];
      n.clk_ext               = ~s_r.main_c[SOURCE_BIT];
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= ST_RST;
      end else begin
         s_r <= n;
      end
   end

   assign hrdata            = s_r.rdata;
   assign hreadyout         = s_r.rdy;
   assign hresp             = s_r.resp;
   assign lcd_level         = s_r.level;
   assign lcd_oe            = s_r.oe;
   assign power_out         = s_r.pwr;
   assign clock_is_external = s_r.clk_ext;
   assign frame_irq         = s_r.irq;

   tripler_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.bus == BUS_WR && s_r.waddr == SUPPLY_OFS
      |-> ##2 power_out.pump_tripler == $past(hwdata[MULT_BIT], 2))
      else $error("pump multiplier does not follow write");

   buffer_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.bus == BUS_WR && s_r.waddr == SUPPLY_OFS
      |-> ##2 power_out.bias_buffer_on != $past(hwdata[BYPASS_BIT], 2))
      else $error("bias buffer does not follow bypass write");

   ext_supply_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.bus == BUS_WR && s_r.waddr == SUPPLY_OFS && hwdata[1:0] == VSUP_EXT
      |-> ##2 power_out.ext_supply_select)
      else $error("external supply not selected");

   wait_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_wait && !cpu_stop && !s_r.power_c[WAIT_BIT] && s_r.main_c[ENABLE_BIT]
      |=> lcd_oe == $past(s_r.pen))
      else $error("drive lost in wait mode");

   stop_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_stop && !cpu_wait && !s_r.power_c[STOP_BIT] && s_r.main_c[ENABLE_BIT]
      |=> lcd_oe == $past(s_r.pen))
      else $error("drive lost in stop mode");

   stop_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_stop && s_r.power_c[STOP_BIT] |=> lcd_oe == '0)
      else $error("drive still on in stop mode");

   clk_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_r.main_c[SOURCE_BIT] |=> clock_is_external)
      else $error("external clock not selected");

   irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !n.power_c[IRQEN_BIT] |=> !frame_irq)
      else $error("interrupt raised while disabled");

   disabled_hiz_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_r.main_c[ENABLE_BIT] |=> lcd_oe == '0)
      else $error("outputs driven while module disabled");

   backplane_ph_a: assert property (@(posedge hclk) disable iff (!hresetn)
      drive_on && s_r.pen[0] && s_r.bpen[0]
      |=> lcd_oe[0] && lcd_level[0] == $past(s_r.wf[0][seq_phase]))
      else $error("backplane level does not match phase mask");
endmodule

// [tb/lcd_glass_model.sv]
// Passive glass model: resolves each pin as the panel electrode sees it
`timescale 1ns/1ps
module lcd_glass_model
   import seg_lcd_pkg::*;
(
   input  wire logic                hclk,
   input  wire logic [NUM_PINS-1:0] lcd_level,
   input  wire logic [NUM_PINS-1:0] lcd_oe,
   output logic [NUM_PINS-1:0]      pin_seen
);
   logic [NUM_PINS-1:0] last_r;

   // Floating electrodes show the inverse of the last level, never a kind value
   always_comb begin
      pin_seen = (lcd_oe & lcd_level) | (~lcd_oe & ~last_r);
   end

   // Remember the last driven level of every pin
   always @(posedge hclk) begin
      last_r <= (lcd_oe & lcd_level) | (~lcd_oe & last_r);
   end
endmodule

// [tb/test_seg_lcd_ctrl.sv]
// Register-level bench of the segment display driver with a glass model
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_seg_lcd_ctrl;
   import seg_lcd_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic ext_osc_tick, alt_clk_tick, cpu_wait, cpu_stop, ext_on, alt_on;
   logic clock_is_external, frame_irq;
   logic [1:0]          htrans;
   logic [2:0]          hsize;
   logic [31:0]         haddr, hwdata, hrdata, rd;
   logic [NUM_PINS-1:0] lcd_level, lcd_oe, pin_seen;
   power_ctl_s          power_out;
   logic [7:0]          seen;
   int                  err_count, tests_run, bad, p8, per;
   localparam logic [NUM_PINS-1:0] PINS = 64'h0000_0000_00FF_FFFF;

   seg_lcd_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ext_osc_tick(ext_osc_tick), .alt_clk_tick(alt_clk_tick), .cpu_wait(cpu_wait),
      .cpu_stop(cpu_stop), .lcd_level(lcd_level), .lcd_oe(lcd_oe),
      .power_out(power_out), .clock_is_external(clock_is_external),
      .frame_irq(frame_irq));
   lcd_glass_model glass (.hclk(hclk), .lcd_level(lcd_level), .lcd_oe(lcd_oe),
      .pin_seen(pin_seen));

   always #4 hclk = ~hclk;

   // Oscillator ticks, one per clock while a source runs
   always @(posedge hclk) begin
      ext_osc_tick <= ext_on;
      alt_clk_tick <= alt_on;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Bounded wait for hready at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100) begin
         err_count++;
         end_sim();
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
      ahb(1'b0, a, 32'h00000000);
      `CHK("register read", ex, rd)
      `CHK("okay response", 1'b0, hresp)
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   // Watch the glass: backplane phases seen, glitches, pin 8 and pin 0 period
   task automatic observe(input int n);
      int last;
      logic prev;
      seen = 8'h00; bad = 0; p8 = 0; per = 0; last = -1; prev = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge hclk);
         #1;
         if ($onehot(pin_seen[7:0])) seen = seen | pin_seen[7:0];
         else bad++;
         if (pin_seen[8] === 1'b1) p8++;
         if (pin_seen[0] === 1'b1 && prev === 1'b0) begin
            if (last >= 0) per = i - last;
            last = i;
         end
         prev = pin_seen[0];
      end
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge hclk);
      err_count++;
      end_sim();
   end

   initial begin
      logic [13:0] sup [3];
      hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
      hsize = 3'h2; hwdata = 0; ext_on = 0; alt_on = 0; cpu_wait = 0; cpu_stop = 0;
      ext_osc_tick = 0; alt_clk_tick = 0; err_count = 0; tests_run = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      cycles(2);
      rd_chk(MAIN_OFS, 32'h00000003);
      rd_chk(SUPPLY_OFS, 32'h00000000);
      `CHK("idle drive", 64'h0, lcd_oe)
      `CHK("ext source", 1'b1, clock_is_external)
      `CHK("reset power", 6'h08, power_out)
      ahb(1'b1, 8'h30, 32'hFFFFFFFF);
      rd_chk(8'h30, 32'h00000000);
      // Supply settings against the analog controls
      sup[0] = {8'hC6, 6'h34}; sup[1] = {8'h82, 6'h2C}; sup[2] = {8'h81, 6'h28};
      foreach (sup[k]) begin
         ahb(1'b1, SUPPLY_OFS, {24'h0, sup[k][13:6]});
         cycles(2);
         `CHK("power ctl", sup[k][5:0], power_out)
      end
      // Pins 0-7 backplanes with a scrambled phase map, pin 8 frontplane on phase 4
      ahb(1'b1, PEN_LO_OFS, 32'h00FFFFFF);
      ahb(1'b1, BP_LO_OFS, 32'h000000FF);
      ahb(1'b1, WF_BASE, 32'h08040201);
      ahb(1'b1, WF_BASE + 8'h04, 32'h10204080);
      ahb(1'b1, WF_BASE + 8'h08, 32'h00000010);
      ahb(1'b1, MAIN_OFS, 32'h00000007);
      ext_on <= 1'b1;
      cycles(3);
      `CHK("still off", 64'h0, lcd_oe)
      ahb(1'b1, MAIN_OFS, 32'h00000087);
      cycles(3);
      `CHK("pin drive", PINS, lcd_oe)
      observe(400);
      `CHK("eight phases", 8'hFF, seen)
      `CHK("one bp at a time", 0, bad)
      ahb(1'b1, MAIN_OFS, 32'h000000C7);
      cycles(2);
      `CHK("alt source", 1'b0, clock_is_external)
      observe(200);
      `CHK("frozen phase", 1'b1, $onehot(seen))
      alt_on <= 1'b1;
      observe(400);
      `CHK("alt ticks", 8'hFF, seen)
      alt_on <= 1'b0;
      ahb(1'b1, MAIN_OFS, 32'h000000AF);
      observe(2300);
      `CHK("frame period", 23 * 6 * 8, per)
      ahb(1'b1, MAIN_OFS, 32'h00000083);
      // Let a phase left over from the eight-phase sweep wrap first
      cycles(4);
      observe(200);
      `CHK("four phases", 8'h0F, seen)
      `CHK("pin8 plain", 0, p8)
      ahb(1'b1, BLINK_OFS, 32'h00000088);
      observe(400);
      `CHK("alt blink", 1'b1, p8 > 0)
      ahb(1'b1, BLINK_OFS, 32'h00000080);
      observe(400);
      `CHK("blank blink", 0, p8)
      // Low power modes
      cpu_stop <= 1'b1;
      cycles(3);
      `CHK("stop on", PINS, lcd_oe)
      ahb(1'b1, POWER_OFS, 32'h00000001);
      cycles(3);
      `CHK("stop off", 64'h0, lcd_oe)
      cpu_stop <= 1'b0;
      cpu_wait <= 1'b1;
      cycles(3);
      `CHK("wait on", PINS, lcd_oe)
      cpu_wait <= 1'b0;
      // Frame interrupt: flag with enable off, then enable, mask, clear
      observe(200);
      rd_chk(STATUS_OFS, 32'h00000001);
      `CHK("irq masked", 1'b0, frame_irq)
      ahb(1'b1, IRQ_EN_OFS, 32'h00000001);
      cycles(3);
      `CHK("irq on", 1'b1, frame_irq)
      ahb(1'b1, IRQ_EN_OFS, 32'h00000000);
      cycles(3);
      `CHK("irq off", 1'b0, frame_irq)
      ext_on <= 1'b0;
      cycles(300);
      ahb(1'b1, IRQ_CLR_OFS, 32'h00000001);
      rd_chk(STATUS_OFS, 32'h00000000);
      ahb(1'b1, IRQ_EN_OFS, 32'h00000001);
      cycles(3);
      `CHK("irq cleared", 1'b0, frame_irq)
      end_sim();
   end
endmodule
